// file: msr_mode_sense.sv
module msr_mode_sense import msr_pkg::*; #(
	parameter logic [15:0] TRANSPORT_ADDR = 16'h0000,
	parameter logic [15:0] STORAGE_START = 16'h0001,
	parameter logic [15:0] STORAGE_COUNT = 16'h0010,
	parameter logic [15:0] IE_ADDR = 16'h0100,
	parameter logic [15:0] IE_COUNT = 16'h0001,
	parameter logic [15:0] DT_START = 16'h0200,
	parameter logic [15:0] DT_COUNT = 16'h0001
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// interrupt
	output logic irq
);
	msr_ext_if ext();

	// bus slave
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic irq_reg;
	logic req;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic [31:0] wmask;

	assign req = avs_read || avs_write;
	assign acc = req && !wait_reg;
	assign wr_acc = acc && avs_write;
	assign rd_acc = acc && avs_read;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// registers
	logic [31:0] cdb_lo_reg;
	logic [15:0] cdb_hi_reg;
	logic busy_reg;
	logic [8:0] pos_reg;
	logic [8:0] total_reg;
	logic [8:0] full_reg;
	logic [NPAGE-1:0] sel_reg;
	logic [1:0] pctl_reg;
	logic [3:0] sk_reg;
	logic cd_reg;
	logic [7:0] asc_reg;
	logic [7:0] ascq_reg;
	logic [15:0] fp_reg;
	logic [IRQ_W-1:0] ist_reg;
	logic [IRQ_W-1:0] imask_reg;
	logic win_reg;
	logic sel_seen_reg;

	// command decode
	logic [7:0] cdb_opc;
	logic [1:0] cdb_pctl;
	logic [5:0] cdb_page;
	logic [7:0] cdb_alloc;
	logic [NPAGE-1:0] sel_next;
	logic [8:0] full_next;
	logic [8:0] total_next;
	logic start;
	logic opc_ok;
	logic page_ok;

	assign cdb_opc = cdb_lo_reg[7:0];
	assign cdb_pctl = cdb_lo_reg[23:22]; // R17
	assign cdb_page = cdb_lo_reg[21:16]; // R17
	assign cdb_alloc = cdb_hi_reg[7:0]; // R17
	// block_descriptor_disable in cdb_lo_reg[11] is never looked at
	assign start = wr_acc && (avs_address == REG_CTRL) && avs_writedata[0] && !busy_reg; // R4
	assign opc_ok = (cdb_opc == OPC_MODE_SENSE); // R17
	assign page_ok = (sel_next != '0);

	always_comb begin
		sel_next = '0;
		full_next = HDR_LEN; // R3
		for (int i = 0; i < NPAGE; i++) begin
			if ((cdb_page == PCODE_ALL) || (cdb_page == page_code(3'(i)))) begin
				sel_next[i] = 1'b1; // R9
				full_next = full_next + page_bytes(3'(i));
			end
		end
	end

	// smaller of list size and allocation length
	assign total_next = (full_next < {1'b0, cdb_alloc}) ? full_next : {1'b0, cdb_alloc}; // R11

	// position to page and offset, pages in ascending order
	logic [8:0] rel;
	logic [2:0] cur_pg;
	logic [6:0] cur_off;
	logic found;
	always_comb begin
		rel = pos_reg - HDR_LEN;
		cur_pg = '0;
		cur_off = '0;
		found = 1'b0;
		for (int i = 0; i < NPAGE; i++) begin
			if (!found && sel_reg[i]) begin
				if (rel < page_bytes(3'(i))) begin
					cur_pg = 3'(i); // R9
					cur_off = rel[6:0];
					found = 1'b1;
				end else begin
					rel = rel - page_bytes(3'(i));
				end
			end
		end
	end

	logic [7:0] rom_byte;
	logic [7:0] hdr_byte;
	logic [7:0] out_byte;
	logic last;

	msr_page_rom #(
		.TRANSPORT_ADDR(TRANSPORT_ADDR),
		.STORAGE_START(STORAGE_START),
		.STORAGE_COUNT(STORAGE_COUNT),
		.IE_ADDR(IE_ADDR),
		.IE_COUNT(IE_COUNT),
		.DT_START(DT_START),
		.DT_COUNT(DT_COUNT)
	) u_rom (
		.page_idx(cur_pg),
		.offset(cur_off),
		.pctl(pctl_reg),
		.ext_byte(ext.rdata),
		.data(rom_byte)
	);

	assign ext.raddr = 5'(cur_off - 7'(PAGE_HDR_LEN));
	// header byte 0 is n-3 with n the last byte index of the full list
	assign hdr_byte = (pos_reg == 9'h000) ? 8'(full_reg - HDR_LEN) : 8'h00; // R12
	assign out_byte = (pos_reg < HDR_LEN) ? hdr_byte : rom_byte; // R3 R12
	assign last = (pos_reg == total_reg - 9'h001);

	// mode select parameter check
	logic [7:0] ms_len;
	logic ms_ps;
	logic [5:0] ms_code;
	logic [7:0] ms_plen;
	logic ms_wr;
	logic [2:0] ms_idx;
	logic ms_known;
	logic [8:0] ms_expect;
	logic ms_len_err;
	logic ms_fld_err;

	assign ms_wr = wr_acc && (avs_address == REG_MSEL_CMD);
	assign ms_len = avs_writedata[7:0];
	assign ms_ps = avs_writedata[15];
	assign ms_code = avs_writedata[13:8];
	assign ms_plen = avs_writedata[23:16];

	always_comb begin
		ms_idx = '0;
		ms_known = 1'b0;
		for (int i = 0; i < NPAGE; i++) begin
			if (ms_code == page_code(3'(i))) begin
				ms_idx = 3'(i);
				ms_known = 1'b1;
			end
		end
	end

	assign ms_expect = HDR_LEN + page_bytes(ms_idx);
	assign ms_len_err = ms_known && ({1'b0, ms_len} != ms_expect); // R1
	assign ms_fld_err = !ms_known || ms_ps || (ms_plen != page_len(ms_idx)); // R2

	// external data writes, only after an accepted select of that page
	logic ms_dwr;
	assign ms_dwr = wr_acc && (avs_address == REG_MSEL_DATA) && win_reg;
	assign ext.we = ms_dwr; // R15
	assign ext.waddr = avs_writedata[12:8];
	assign ext.wdata = avs_writedata[7:0];

	msr_ext_store u_store (
		.clk(clk),
		.ext(ext.store)
	);

	// data register read pops one byte
	logic pop;
	assign pop = rd_acc && (avs_address == REG_DATA) && busy_reg;

	// interrupt events and read-to-clear
	logic [IRQ_W-1:0] ev;
	logic ist_clr;
	assign ev[IRQ_SENSE_DONE] = (start && opc_ok && page_ok && total_next == 9'h000) ||
		(pop && last);
	assign ev[IRQ_SEL_ERR] = ms_wr && (ms_len_err || ms_fld_err);
	assign ev[IRQ_SEL_OK] = ms_wr && !ms_len_err && !ms_fld_err;
	assign ev[IRQ_CDB_ERR] = start && !(opc_ok && page_ok);
	assign ist_clr = rd_acc && (avs_address == REG_IRQ_STATUS);

	// read mux
	logic [31:0] rmux;
	always_comb begin
		unique case (avs_address)
			REG_CDB_LO: rmux = cdb_lo_reg;
			REG_CDB_HI: rmux = {16'h0000, cdb_hi_reg};
			REG_STATE: rmux = {7'h00, total_reg, 6'h00, pctl_reg, 6'h00, sel_seen_reg, busy_reg};
			REG_DATA: rmux = busy_reg ? {22'h0, last, 1'b1, out_byte} : 32'h00000000;
			REG_SENSE: rmux = {8'h00, ascq_reg, asc_reg, 3'h0, cd_reg, sk_reg};
			REG_FIELD_PTR: rmux = {16'h0000, fp_reg};
			REG_IRQ_STATUS: rmux = {28'h0000000, ist_reg};
			REG_IRQ_MASK: rmux = {28'h0000000, imask_reg};
			default: rmux = 32'h00000000;
		endcase
	end

	// bus handshake: one wait cycle, answer on the next edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg <= !(req && wait_reg);
			if (req && wait_reg) begin
				rdata_reg <= avs_read ? rmux : 32'h00000000;
			end
		end
	end

	// command block and bus-written controls
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cdb_lo_reg <= '0;
			cdb_hi_reg <= '0;
			imask_reg <= '0;
		end else if (wr_acc) begin
			if (avs_address == REG_CDB_LO) begin
				cdb_lo_reg <= (cdb_lo_reg & ~wmask) | (avs_writedata & wmask);
			end
			if (avs_address == REG_CDB_HI) begin
				cdb_hi_reg <= (cdb_hi_reg & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
			end
			if (avs_address == REG_IRQ_MASK && avs_byteenable[0]) begin
				imask_reg <= avs_writedata[IRQ_W-1:0];
			end
		end
	end

	// transfer engine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
			pos_reg <= '0;
			total_reg <= '0;
			full_reg <= '0;
			sel_reg <= '0;
			pctl_reg <= '0;
		end else if (start && opc_ok && page_ok) begin
			busy_reg <= (total_next != 9'h000); // R10
			pos_reg <= '0;
			total_reg <= total_next; // R11
			full_reg <= full_next;
			sel_reg <= sel_next;
			pctl_reg <= cdb_pctl;
		end else if (pop) begin
			pos_reg <= pos_reg + 9'h001;
			busy_reg <= !last; // R11
		end
	end

	// sense data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sk_reg <= '0;
			cd_reg <= 1'b0;
			asc_reg <= '0;
			ascq_reg <= '0;
			fp_reg <= '0;
		end else if (ms_wr && ms_len_err) begin
			sk_reg <= SK_ILLEGAL; // R1
			cd_reg <= 1'b1; // R1
			asc_reg <= ASC_LIST_LEN; // R1
			ascq_reg <= ASCQ_NONE;
			fp_reg <= FP_LIST_LEN; // R1
		end else if (ms_wr && ms_fld_err) begin
			sk_reg <= SK_ILLEGAL; // R2
			cd_reg <= 1'b0; // R2
			asc_reg <= ASC_BAD_PARAM; // R2
			ascq_reg <= ASCQ_NONE;
			fp_reg <= (ms_ps || !ms_known) ? FP_PAGE_CODE : FP_PAGE_LEN;
		end else if (start && !(opc_ok && page_ok)) begin
			sk_reg <= SK_ILLEGAL;
			cd_reg <= 1'b1;
			asc_reg <= opc_ok ? ASC_BAD_CDB : ASC_BAD_OPCODE;
			ascq_reg <= ASCQ_NONE;
			fp_reg <= opc_ok ? FP_CDB_PAGE : 16'h0000;
		end else if (start || ms_wr) begin
			sk_reg <= '0;
			cd_reg <= 1'b0;
			asc_reg <= '0;
			ascq_reg <= '0;
			fp_reg <= '0;
		end
	end

	// select window and history
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			win_reg <= 1'b0;
			sel_seen_reg <= 1'b0;
		end else if (ms_wr) begin
			win_reg <= !ms_len_err && !ms_fld_err && (ms_idx == PG_EXT); // R15
			sel_seen_reg <= sel_seen_reg || (!ms_len_err && !ms_fld_err); // R5
		end else if (ms_dwr && ext.waddr == 5'(EXT_LEN - 1)) begin
			win_reg <= 1'b0;
		end
	end

	// read-clear drops only the bits the read returned, so no event is lost
	logic [IRQ_W-1:0] ist_kept;
	logic [IRQ_W-1:0] imask_next;
	assign ist_kept = ist_clr ? (ist_reg & ~rdata_reg[IRQ_W-1:0]) : ist_reg;
	// irq follows a mask write at the same edge
	assign imask_next = (wr_acc && (avs_address == REG_IRQ_MASK) && avs_byteenable[0]) ?
		avs_writedata[IRQ_W-1:0] : imask_reg;

	// sticky status, set wins over read-clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ist_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			ist_reg <= ist_kept | ev;
			irq_reg <= |((ist_kept | ev) & imask_next);
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign irq = irq_reg;
endmodule

// file: msr_pkg.sv
// What this block does
// R1: Select list length wrong: sense 5/1A/00, command block flagged, field pointer 0004.
// R2: Select invalid field or savable bit set: sense 5/26/00, command flag clear.
// R3: Mode sense returns a four-byte header then zero or more pages.
// R4: Block descriptor disable bit ignored; descriptors never emitted.
// R5: Control 0 returns current values: last select, else saved, else defaults; page 3E reads the store, which has no reset, even before any select.
// R6: Control 1 returns changeable bits as ones; code and length stay real.
// R7: Control 2 returns defaults, zero for unsupported parameters.
// R8: Control 3 returns saved values, defaults when nothing was saved; page 3E reads the unreset store even then.
// R9: Codes 1D,1F,22,3D,3E accepted; 3F returns all in ascending order.
// R10: Allocation length zero transfers no data.
// R11: Transfer ends at the smaller of list size and allocation length.
// R12: Header byte 0 holds length minus four, bytes 1-3 zero, pages at 4.
// R13: Element page byte 0 savable bit set, code 1D, length byte 18.
// R14: Element page two-byte address and count fields, transport count 0001, bytes 18-19 zero.
// R15: External data page 3E is a 32-byte store written only by select.
// R16: Capabilities page code 1F, savable clear, length 12 hex.
// R17: Six-byte command, opcode 1A, control byte2[7:6], code byte2[5:0], length byte4.
package msr_pkg;
	// register byte offsets
	localparam logic [5:0] REG_CDB_LO = 6'h00;
	localparam logic [5:0] REG_CDB_HI = 6'h04;
	localparam logic [5:0] REG_CTRL = 6'h08;
	localparam logic [5:0] REG_STATE = 6'h0c;
	localparam logic [5:0] REG_DATA = 6'h10;
	localparam logic [5:0] REG_MSEL_CMD = 6'h14;
	localparam logic [5:0] REG_MSEL_DATA = 6'h18;
	localparam logic [5:0] REG_SENSE = 6'h1c;
	localparam logic [5:0] REG_FIELD_PTR = 6'h20;
	localparam logic [5:0] REG_IRQ_STATUS = 6'h24;
	localparam logic [5:0] REG_IRQ_MASK = 6'h28;
	// interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_SENSE_DONE = 0;
	localparam int IRQ_SEL_ERR = 1;
	localparam int IRQ_SEL_OK = 2;
	localparam int IRQ_CDB_ERR = 3;
	// command fields
	localparam logic [7:0] OPC_MODE_SENSE = 8'h1a;
	localparam logic [5:0] PCODE_ALL = 6'h3f;
	localparam logic [1:0] PCTL_CURRENT = 2'h0;
	localparam logic [1:0] PCTL_CHANGEABLE = 2'h1;
	localparam logic [1:0] PCTL_DEFAULT = 2'h2;
	localparam logic [1:0] PCTL_SAVED = 2'h3;
	// layout
	localparam int NPAGE = 5;
	localparam logic [8:0] HDR_LEN = 9'h004;
	localparam logic [8:0] PAGE_HDR_LEN = 9'h002;
	localparam int EXT_LEN = 32;
	localparam logic [2:0] PG_ELEM = 3'h0;
	localparam logic [2:0] PG_EXT = 3'h4;
	localparam logic [7:0] CFG_PAGE_LEN = 8'h0e;
	localparam logic [15:0] TRANSPORT_COUNT = 16'h0001;
	// sense codes
	localparam logic [3:0] SK_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_LIST_LEN = 8'h1a;
	localparam logic [7:0] ASC_BAD_PARAM = 8'h26;
	localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
	localparam logic [7:0] ASC_BAD_CDB = 8'h24;
	localparam logic [7:0] ASCQ_NONE = 8'h00;
	localparam logic [15:0] FP_LIST_LEN = 16'h0004;
	localparam logic [15:0] FP_PAGE_CODE = 16'h0004;
	localparam logic [15:0] FP_PAGE_LEN = 16'h0005;
	localparam logic [15:0] FP_CDB_PAGE = 16'h0002;

	// pages in ascending code order
	function automatic logic [5:0] page_code(input logic [2:0] i);
		case (i)
			3'h0: page_code = 6'h1d;
			3'h1: page_code = 6'h1f;
			3'h2: page_code = 6'h22;
			3'h3: page_code = 6'h3d;
			default: page_code = 6'h3e;
		endcase
	endfunction

	function automatic logic [7:0] page_len(input logic [2:0] i);
		case (i)
			3'h0: page_len = 8'h12;
			3'h1: page_len = 8'h12;
			3'h2: page_len = 8'h52;
			3'h3: page_len = CFG_PAGE_LEN;
			default: page_len = 8'h20;
		endcase
	endfunction

	function automatic logic page_ps(input logic [2:0] i);
		page_ps = (i == 3'h0) || (i == 3'h2) || (i == 3'h3);
	endfunction

	function automatic logic [8:0] page_bytes(input logic [2:0] i);
		page_bytes = {1'b0, page_len(i)} + PAGE_HDR_LEN;
	endfunction
endpackage

// file: msr_ext_if.sv
interface msr_ext_if;
	logic we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	logic [4:0] raddr;
	logic [7:0] rdata;
	modport store(input we, input waddr, input wdata, input raddr, output rdata);
	modport user(output we, output waddr, output wdata, output raddr, input rdata);
endinterface

// file: msr_ext_store.sv
module msr_ext_store import msr_pkg::*; #(
	parameter int DEPTH = EXT_LEN
) (
	// clock
	input wire logic clk,
	// store access
	msr_ext_if.store ext
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ext.we) begin
			mem[ext.waddr] <= ext.wdata; // R15
		end
	end

	assign ext.rdata = mem[ext.raddr];
endmodule

// file: msr_page_rom.sv
module msr_page_rom import msr_pkg::*; #(
	parameter logic [15:0] TRANSPORT_ADDR = 16'h0000,
	parameter logic [15:0] STORAGE_START = 16'h0001,
	parameter logic [15:0] STORAGE_COUNT = 16'h0010,
	parameter logic [15:0] IE_ADDR = 16'h0100,
	parameter logic [15:0] IE_COUNT = 16'h0001,
	parameter logic [15:0] DT_START = 16'h0200,
	parameter logic [15:0] DT_COUNT = 16'h0001
) (
	// byte select
	input wire logic [2:0] page_idx,
	input wire logic [6:0] offset,
	input wire logic [1:0] pctl,
	// external store byte
	input wire logic [7:0] ext_byte,
	// result
	output logic [7:0] data
);
	logic [15:0] elem_word;
	logic [7:0] elem_byte;
	logic [7:0] ext_val;
	logic [7:0] body;

	// element address fields, big endian
	always_comb begin
		case (offset[6:1])
			6'h01: elem_word = TRANSPORT_ADDR;
			6'h02: elem_word = TRANSPORT_COUNT;
			6'h03: elem_word = STORAGE_START;
			6'h04: elem_word = STORAGE_COUNT;
			6'h05: elem_word = IE_ADDR;
			6'h06: elem_word = IE_COUNT;
			6'h07: elem_word = DT_START;
			6'h08: elem_word = DT_COUNT;
			default: elem_word = 16'h0000;
		endcase
	end // R14

	assign elem_byte = offset[0] ? elem_word[7:0] : elem_word[15:8];
	// external page: all bits changeable, default zero, current equals saved
	assign ext_val = (pctl == PCTL_CHANGEABLE) ? 8'hff :
		(pctl == PCTL_DEFAULT) ? 8'h00 : ext_byte; // R5 R6 R7 R8 R15
	// element page fields are fixed: none changeable, saved equals default
	assign body = (page_idx == PG_ELEM) ? ((pctl == PCTL_CHANGEABLE) ? 8'h00 : elem_byte) :
		(page_idx == PG_EXT) ? ext_val : 8'h00; // R6 R7 R8
	assign data = (offset == 7'h00) ? {page_ps(page_idx), 1'b0, page_code(page_idx)} :
		(offset == 7'h01) ? page_len(page_idx) : body; // R6 R13 R16
endmodule

// file: msr_chk.sv
module msr_chk import msr_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// interrupt
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	wire logic req = avs_read | avs_write;
	wire logic rd_done = avs_read & ~avs_waitrequest;
	wire logic sense_rd = rd_done & (avs_address == REG_SENSE);
	wire logic data_rd = rd_done & (avs_address == REG_DATA);
	wire logic st_rd = avs_read & (avs_address == REG_IRQ_STATUS);
	wire logic mask_wr = avs_write & (avs_address == REG_IRQ_MASK);
	wire logic irq_acc = ~avs_waitrequest & (st_rd | mask_wr);
	a_wait_one:
		assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_short:
		assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_irq_fall:
		assert property ($fell(irq) |-> $past(irq_acc))
		else $error("irq dropped without status read or mask write");
	a_sense_key:
		assert property (sense_rd && avs_readdata[3:0] != 4'h0 |->
			avs_readdata[3:0] == SK_ILLEGAL && avs_readdata[23:16] == ASCQ_NONE)
		else $error("sense key or qualifier wrong");
	a_len_cd:
		assert property (sense_rd && avs_readdata[15:8] == ASC_LIST_LEN |-> avs_readdata[4])
		else $error("list length error without command flag");
	a_field_cd:
		assert property (sense_rd && avs_readdata[15:8] == ASC_BAD_PARAM |-> !avs_readdata[4])
		else $error("field error with command flag");
	a_last_valid:
		assert property (data_rd && avs_readdata[9] |->
			avs_readdata[8] && avs_readdata[31:10] == 22'h0)
		else $error("last byte not valid");
	a_idle_zero:
		assert property (data_rd && !avs_readdata[8] |-> avs_readdata == 32'h0)
		else $error("data read while idle not zero");
endmodule

// file: msr_host.sv
module msr_host import msr_pkg::*; (
	// clock
	input wire logic clk,
	// avalon-mm master
	output logic [5:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	// hold the request until waitrequest is sampled low
	task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_read <= ~w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		access(1'b1, a, d, dummy);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		access(1'b0, a, 32'h0, q);
	endtask
	// block descriptor disable set on purpose
	task automatic sense_cmd(input logic [1:0] pc, input logic [5:0] code, input logic [7:0] len);
		wr(REG_CDB_LO, {8'h00, pc, code, 8'h08, OPC_MODE_SENSE});
		wr(REG_CDB_HI, {24'h0, len});
		wr(REG_CTRL, 32'h1);
	endtask
endmodule

// file: msr_tb.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import msr_pkg::*;
	logic clk;
	logic sys_rst;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic [31:0] q;
	logic [7:0] got [0:255];
	int fails;
	int tests_run;
	msr_mode_sense uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq));
	msr_host host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [7:0] xd(input int i);
		return 8'(i) ^ 8'ha5;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic pull(input int n);
		for (int i = 0; i < n; i++) begin
			host.rd(REG_DATA, q);
			got[i] = q[7:0];
			check("flags", q[9:8], {i == n - 1, 1'b1});
		end
		host.rd(REG_STATE, q);
		check("busy", q[0], 1'b0);
	endtask
	task automatic t_all;
		logic [7:0] e [0:177];
		logic [159:0] elem;
		logic [0:3][23:0] hd;
		elem = 160'h9d12_0000_0001_0001_0010_0100_0001_0200_0001_0000;
		hd = {24'h181f12, 24'h2ca252, 24'h80bd0e, 24'h903e20};
		foreach (e[i]) e[i] = 8'h00;
		e[0] = 8'hae;
		for (int i = 0; i < 20; i++) e[4 + i] = elem[159 - 8 * i -: 8];
		for (int i = 0; i < 4; i++) begin
			e[hd[i][23:16]] = hd[i][15:8];
			e[hd[i][23:16] + 1] = hd[i][7:0];
		end
		for (int i = 0; i < 32; i++) e[146 + i] = xd(i);
		host.wr(REG_MSEL_CMD, 32'h0020_3e26);
		for (int i = 0; i < 32; i++) host.wr(REG_MSEL_DATA, {19'h0, 5'(i), xd(i)});
		host.wr(REG_IRQ_MASK, 32'h1);
		host.sense_cmd(PCTL_CURRENT, PCODE_ALL, 8'hff);
		host.rd(REG_STATE, q);
		check("state", {q[24:16], q[1:0]}, {9'd178, 2'b11});
		pull(178);
		for (int i = 0; i < 178; i++) check("list byte", got[i], e[i]);
		check("irq set", irq, 1'b1);
		host.rd(REG_IRQ_STATUS, q);
		check("status", q[3:0], 4'h5);
		@(negedge clk);
		check("irq clear", irq, 1'b0);
		$display("t_all done");
	endtask
	task automatic t_sel;
		logic [31:0] c [0:2];
		logic [31:0] s [0:2];
		c = '{32'h0020_3e25, 32'h0020_be26, 32'h0020_3e26};
		s = '{32'h0000_1a15, 32'h0000_2605, 32'h0};
		for (int i = 0; i < 3; i++) begin
			host.wr(REG_MSEL_CMD, c[i]);
			host.rd(REG_SENSE, q);
			check("sense", q, s[i]);
			host.rd(REG_FIELD_PTR, q);
			check("field pointer", q[15:0], (i < 2) ? 16'h0004 : 16'h0000);
		end
		host.sense_cmd(PCTL_CURRENT, 6'h10, 8'hff);
		host.rd(REG_SENSE, q);
		check("bad page", q, 32'h0000_2415);
		host.rd(REG_FIELD_PTR, q);
		check("page pointer", q[15:0], 16'h0002);
		host.wr(REG_CDB_LO, {16'h0000, 8'h08, 8'h12});
		host.wr(REG_CTRL, 32'h1);
		host.rd(REG_SENSE, q);
		check("bad opcode", q, 32'h0000_2015);
		check("irq masked", irq, 1'b0);
		host.wr(REG_IRQ_MASK, 32'hf);
		@(negedge clk);
		check("irq unmasked", irq, 1'b1);
		host.rd(REG_IRQ_STATUS, q);
		check("status", q[3:0], 4'he);
		@(negedge clk);
		check("irq clear", irq, 1'b0);
		host.rd(6'h2c, q);
		check("unmapped", q, 32'h0);
		$display("t_sel done");
	endtask
	task automatic t_trunc;
		host.sense_cmd(PCTL_CHANGEABLE, 6'h1d, 8'd5);
		pull(5);
		check("head", {got[0], got[1], got[4]}, 24'h14009d);
		host.rd(REG_IRQ_STATUS, q);
		check("pull done", q[3:0], 4'h1);
		host.sense_cmd(PCTL_DEFAULT, 6'h1f, 8'h00);
		host.rd(REG_STATE, q);
		check("busy zero", q[0], 1'b0);
		host.rd(REG_DATA, q);
		check("no data", q, 32'h0);
		host.rd(REG_IRQ_STATUS, q);
		check("done", q[3:0], 4'h1);
		$display("t_trunc done");
	endtask
	task automatic t_pc;
		logic [7:0] x;
		for (int p = 1; p < 4; p++) begin
			host.sense_cmd(2'(p), 6'h3e, 8'd40);
			pull(38);
			check("ext head", {got[0], got[4], got[5]}, 24'h223e20);
			for (int i = 0; i < 32; i++) begin
				x = (p == 1) ? 8'hff : (p == 2) ? 8'h00 : xd(i);
				check("ext byte", got[6 + i], x);
			end
		end
		$display("t_pc done");
	endtask
	initial begin
		fails = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_all();
		t_sel();
		t_trunc();
		t_pc();
		conclude();
	end
	initial begin
		#3000000;
		fails++;
		conclude();
	end
endmodule
bind msr_mode_sense msr_chk u_chk (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq));
